// File: hw/comp_latch_consts.vh
// register offsets, field positions, reset values for the comparator back end
`ifndef COMP_LATCH_CONSTS_VH
`define COMP_LATCH_CONSTS_VH

`define ADDR_W 4
`define OFS_COMP_TWO_CTRL_ONE 4'h0
`define OFS_LATCH_CTRL 4'h1

`define BIT_SYNC_EN 0
`define BIT_GATE_SEL 1
`define BIT_REF_TWO 4
`define BIT_REF_ONE 5
`define BIT_MIRROR_TWO 6
`define BIT_MIRROR_ONE 7

`define BIT_RESET_PULSE 2
`define BIT_SET_PULSE 3
`define BIT_SEL_LO 6
`define BIT_SEL_HI 7

`define RST_COMP_TWO_CTRL_ONE 8'h02
`define RST_LATCH_SEL 2'h0
`define RST_GATE_SEL 1'b1
`define RST_SYNC_EN 1'b0
`define RST_REF_ONE 1'b0
`define RST_REF_TWO 1'b0

`define SEL_BOTH_COMPS 2'h0
`define SEL_ONE_AND_QN 2'h1
`define SEL_TWO_AND_Q 2'h2
`define SEL_Q_AND_QN 2'h3

`endif

// File: hw/sync_three.v
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sync_three (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // level in and filtered level out
    input wire d,
    output reg q
);
    reg s1;
    reg s2;
    reg s3;

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            // change counts only once two later stages agree
            if (s2 == s3)
                q <= s3;
        end
    end
endmodule

// File: hw/sr_latch_cell.v
// clockless reset-dominant set/reset latch
`timescale 1ns/1ps
module sr_latch_cell (
    // active-high inputs
    input wire set_in,
    input wire reset_in,
    // latch outputs
    output wire q,
    output wire q_n
);
    reg state;

    // reset wins when both are high
    always @*
    begin
        if (reset_in)
            state = 1'b0;
        else if (set_in)
            state = 1'b1;
        else
            state = state;
    end

    assign q = state;
    assign q_n = ~state;
endmodule

// File: hw/comp_output_latch.v
// comparator output back end: timer gate, sync, mirror, sr latch, muxes
//
// Behaviour
// - gate select clear uses synced comparator two; set uses external gate pin.
// - comparator two gates timer only while timer on and gating enabled.
// - sync bit set captures comparator two on timer clock falling edge.
// - capture clocked by prescaled timer clock when a prescaler is used.
// - timer counts on rising edge, capture on falling edge, avoiding races.
// - bits 7 and 6 read synchronised, filtered comparator one and two results.
// - reading mirror bits leaves change-detection mismatch state untouched.
// - bit 5 selects programmable or fixed 0.6 V reference for comparator one.
// - bit 4 selects programmable or fixed reference for comparator two.
// - bits 3 and 2 read zero; writes ignored.
// - latch has no clock; set and reset are active high.
// - set by comparator one or set pulse; reset by comparator two or pulse.
// - simultaneous set and reset leaves latch reset.
// - set and reset pulse bits clear themselves after one pulse.
// - two-bit select routes one of four comparator/latch pairings to ports.
// - after reset the muxes route both plain comparator results.
// - latch output selection is independent of comparator enables.
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "comp_latch_consts.vh"
module comp_output_latch (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // register port
    input wire [`ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata,
    // raw comparator results, asynchronous
    input wire comp_one_result,
    input wire comp_two_result,
    // latch enables from the latch control register owner
    input wire comp_one_set_enable,
    input wire comp_two_reset_enable,
    // timer side
    input wire timer_clk,
    input wire timer_on,
    input wire timer_gate_enable,
    input wire external_gate_pin,
    output wire timer_gate,
    output wire synced_comp_two_result,
    // reference routing
    output wire comp_one_ref_select,
    output wire comp_two_ref_select,
    // to port logic
    output wire port_out_one,
    output wire port_out_two,
    output wire latch_q
);

    reg timer_gate_source_select;
    reg comp_two_sync_enable;
    reg ref_one_sel;
    reg ref_two_sel;
    reg [1:0] latch_output_select;
    reg latch_set_pulse;
    reg latch_reset_pulse;
    reg comp_two_captured;
    reg [7:0] next_rdata;
    // datapath nets
    wire mirror_comp_one_result;
    wire mirror_comp_two_result;
    wire latch_qn;
    wire sel_ctrl;
    wire sel_latch;
    reg mux_one;
    reg mux_two;
    reg gate_source;
    reg gate_open;
    reg sync_mux;
    wire latch_set_in;
    wire latch_reset_in;

    // only two addresses decode; the rest read zero and ignore writes
    assign sel_ctrl = (addr == `OFS_COMP_TWO_CTRL_ONE);
    assign sel_latch = (addr == `OFS_LATCH_CTRL);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // gate select leaves reset set, so the comparator cannot gate the
    // timer until software asks for it
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timer_gate_source_select <= `RST_GATE_SEL;
            comp_two_sync_enable <= `RST_SYNC_EN;
            ref_one_sel <= `RST_REF_ONE;
            ref_two_sel <= `RST_REF_TWO;
        end
        else if (wr_en && sel_ctrl)
        begin
            // bits 7:6 read only, 3:2 unimplemented
            ref_one_sel <= wdata[`BIT_REF_ONE];
            ref_two_sel <= wdata[`BIT_REF_TWO];
            timer_gate_source_select <= wdata[`BIT_GATE_SEL];
            comp_two_sync_enable <= wdata[`BIT_SYNC_EN];
        end
    end

    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
            latch_output_select <= `RST_LATCH_SEL;
        else if (wr_en && sel_latch)
            latch_output_select <= wdata[`BIT_SEL_HI:`BIT_SEL_LO];
    end

    // pulse bits live one cycle unless written again; a write always
    // lands, the self-clear only runs on cycles without one
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_set_pulse <= 1'b0;
            latch_reset_pulse <= 1'b0;
        end
        else if (wr_en && sel_latch)
        begin
            latch_set_pulse <= wdata[`BIT_SET_PULSE];
            latch_reset_pulse <= wdata[`BIT_RESET_PULSE];
        end
        else
        begin
            latch_set_pulse <= 1'b0;
            latch_reset_pulse <= 1'b0;
        end
    end

    assign comp_one_ref_select = ref_one_sel;
    assign comp_two_ref_select = ref_two_sel;

    // ------------------------------------------------------------
    // comparator two capture on timer clock
    // ------------------------------------------------------------
    // timer_clk is already post-prescaler; falling edge keeps clear of
    // the timer's rising-edge increment
    always @(negedge timer_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            comp_two_captured <= 1'b0;
        end
        else
        begin
            comp_two_captured <= comp_two_result;
        end
    end

    // with sync off the raw comparator passes straight through and may
    // move mid-increment; the user trades that for lower latency
    always @*
    begin
        if (comp_two_sync_enable)
            sync_mux = comp_two_captured;
        else
            sync_mux = comp_two_result;
    end

    assign synced_comp_two_result = sync_mux;

    // gate is an enable for the rising-edge timer
    always @*
    begin
        if (timer_gate_source_select)
            gate_source = external_gate_pin;
        else
            gate_source = sync_mux;
    end

    // closed unless the timer runs with gating on
    always @*
    begin
        if (timer_on && timer_gate_enable)
            gate_open = gate_source;
        else
            gate_open = 1'b0;
    end

    assign timer_gate = gate_open;

    // ------------------------------------------------------------
    // mirror path
    // ------------------------------------------------------------
    // mirror bits trail the comparators by four core clocks; software
    // gets a clean level, never a half-settled one
    sync_three u_sync_one (
        .core_clk(core_clk),
        .resetn(resetn),
        .d(comp_one_result),
        .q(mirror_comp_one_result)
    );
    sync_three u_sync_two (
        .core_clk(core_clk),
        .resetn(resetn),
        .d(comp_two_result),
        .q(mirror_comp_two_result)
    );

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // reads have no side effect on any change-detection state
    always @*
    begin
        next_rdata = 8'h00;
        case (addr)
            `OFS_COMP_TWO_CTRL_ONE:
            begin
                next_rdata[`BIT_MIRROR_ONE] = mirror_comp_one_result;
                next_rdata[`BIT_MIRROR_TWO] = mirror_comp_two_result;
                next_rdata[`BIT_REF_ONE] = ref_one_sel;
                next_rdata[`BIT_REF_TWO] = ref_two_sel;
                next_rdata[`BIT_GATE_SEL] = timer_gate_source_select;
                next_rdata[`BIT_SYNC_EN] = comp_two_sync_enable;
            end
            `OFS_LATCH_CTRL:
            begin
                // pulse bits are not read back, so they read zero
                next_rdata[`BIT_SEL_HI:`BIT_SEL_LO] = latch_output_select;
            end
            default:
            begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // data stand only in the cycle after the strobe
    always @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= 8'h00;
        end
        else if (rd_en)
        begin
            rdata <= next_rdata;
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // sr latch and output muxes
    // ------------------------------------------------------------
    // comparator terms are raw: the latch has no clock and must follow
    // a comparator edge without waiting for one
    assign latch_set_in = (comp_one_result & comp_one_set_enable) |
        latch_set_pulse;
    assign latch_reset_in = (comp_two_result & comp_two_reset_enable) |
        latch_reset_pulse;

    // the latch keeps its state through resetn: it has no reset input
    // of its own, only the pulse bits are cleared
    sr_latch_cell u_latch (
        .set_in(latch_set_in),
        .reset_in(latch_reset_in),
        .q(latch_q),
        .q_n(latch_qn)
    );

    // no comparator-enable term: selection stands on its own
    // pairing 10 puts the latch on port one, comparator two on port two
    always @*
    begin
        case (latch_output_select)
            `SEL_BOTH_COMPS:
            begin
                mux_one = comp_one_result;
                mux_two = comp_two_result;
            end
            `SEL_ONE_AND_QN:
            begin
                mux_one = comp_one_result;
                mux_two = latch_qn;
            end
            `SEL_TWO_AND_Q:
            begin
                mux_one = latch_q;
                mux_two = comp_two_result;
            end
            default:
            begin
                mux_one = latch_q;
                mux_two = latch_qn;
            end
        endcase
    end

    assign port_out_one = mux_one;
    assign port_out_two = mux_two;
endmodule

// File: sim/timer_side_model.sv
// timer stand-in: prescaled clock and gated counter
`timescale 1ns/1ps
module timer_side_model (
    // gate from the block
    input wire timer_gate,
    // clock and count
    output reg timer_clk,
    output reg [15:0] count
);
    initial
    begin
        timer_clk = 1'b0;
        count = 16'h0000;
    end
    // 210 ns half period never lands on a core rising edge
    always #210 timer_clk = ~timer_clk;
    always @(posedge timer_clk)
    begin
        if (timer_gate)
            count <= count + 16'h0001;
    end
endmodule

// port driver stand-in: a pin shows its signal only when enabled
module port_driver_model (
    // from the block
    input wire port_out_one,
    input wire port_out_two,
    // software port setup
    input wire [1:0] port_direction_bits,
    input wire [1:0] comp_output_enable,
    // pins, pulled low when not driven
    output wire pin_one,
    output wire pin_two
);
    assign pin_one = !port_direction_bits[0] && comp_output_enable[0] &&
        port_out_one;
    assign pin_two = !port_direction_bits[1] && comp_output_enable[1] &&
        port_out_two;
endmodule

// File: sim/comp_latch_props.sv
// port assertions for the comparator back end
`timescale 1ns/1ps
`include "comp_latch_consts.vh"
module comp_latch_props (
    // clock and reset
    input wire core_clk,
    input wire resetn,
    // register port
    input wire [`ADDR_W-1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] rdata,
    // side signals
    input wire comp_two_reset_enable,
    input wire timer_on,
    input wire timer_gate_enable,
    input wire external_gate_pin,
    input wire timer_gate,
    input wire synced_comp_two_result,
    input wire comp_one_ref_select,
    input wire comp_two_ref_select,
    input wire latch_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    wire w1 = wr_en && addr == `OFS_LATCH_CTRL;
    wire r0 = rd_en && addr == `OFS_COMP_TWO_CTRL_ONE;
    AST_GATE_OFF: assert property (
        !(timer_on && timer_gate_enable) |-> !timer_gate)
        else $error("gate open while timer idle");
    AST_GATE_SRC: assert property (
        timer_gate |-> external_gate_pin || synced_comp_two_result)
        else $error("gate open without source");
    AST_RSV_ZERO: assert property (
        r0 |=> rdata[3:2] == 2'h0)
        else $error("unused bits read nonzero");
    AST_REF_READ: assert property (
        r0 |=> rdata[5] == $past(comp_one_ref_select)
            && rdata[4] == $past(comp_two_ref_select))
        else $error("reference bits read wrong");
    AST_REF_WRITE: assert property (
        wr_en && addr == 4'h0 && !wdata[4] |=> !comp_two_ref_select)
        else $error("reference select not cleared");
    AST_PULSE_ZERO: assert property (
        rd_en && addr == `OFS_LATCH_CTRL |=> rdata[3:0] == 4'h0)
        else $error("pulse bits read nonzero");
    AST_LATCH_SET: assert property (
        w1 && wdata[3] && !wdata[2] && !comp_two_reset_enable |=> latch_q)
        else $error("set pulse did not set latch");
    AST_LATCH_RST: assert property (
        w1 && wdata[2] |=> !latch_q)
        else $error("reset pulse did not win");
endmodule
bind comp_output_latch comp_latch_props u_props (.core_clk, .resetn,
    .addr, .wdata, .wr_en, .rd_en, .rdata, .comp_two_reset_enable,
    .timer_on, .timer_gate_enable, .external_gate_pin, .timer_gate,
    .synced_comp_two_result, .comp_one_ref_select, .comp_two_ref_select,
    .latch_q);

// File: sim/test_comp_output_latch.sv
// self-checking bench for the comparator back end
`timescale 1ns/1ps
`include "comp_latch_consts.vh"
module test_comp_output_latch;
    reg core_clk = 1'b0;
    reg resetn = 1'b0;
    reg [`ADDR_W-1:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg comp_one_result = 1'b0;
    reg comp_two_result = 1'b0;
    reg comp_one_set_enable = 1'b0;
    reg comp_two_reset_enable = 1'b0;
    reg timer_on = 1'b0;
    reg timer_gate_enable = 1'b0;
    reg external_gate_pin = 1'b0;
    reg [1:0] port_direction_bits = 2'h3;
    reg [1:0] comp_output_enable = 2'h0;
    wire pin_one;
    wire pin_two;
    wire [7:0] rdata;
    wire timer_clk, timer_gate, synced_comp_two_result, latch_q;
    wire comp_one_ref_select, comp_two_ref_select, port_out_one, port_out_two;
    integer bad_count = 0;
    integer n_tests = 0;
    integer i;
    always #25 core_clk = ~core_clk;
    comp_output_latch DUT (.core_clk, .resetn, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .comp_one_result, .comp_two_result,
        .comp_one_set_enable, .comp_two_reset_enable, .timer_clk, .timer_on,
        .timer_gate_enable, .external_gate_pin, .timer_gate,
        .synced_comp_two_result, .comp_one_ref_select, .comp_two_ref_select,
        .port_out_one, .port_out_two, .latch_q);
    timer_side_model u_timer (.timer_gate, .timer_clk, .count());
    port_driver_model u_port (.port_out_one, .port_out_two,
        .port_direction_bits, .comp_output_enable, .pin_one, .pin_two);
    task final_report;
    begin
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task chk1(input got, input exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask
    task wr(input [3:0] a, input [7:0] d);
    begin
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
        @(posedge core_clk);
    end
    endtask
    task rd(input [3:0] a, input [7:0] exp);
    begin
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(rdata, exp);
        @(posedge core_clk);
    end
    endtask
    task t_regs;
    begin
        rd(4'h0, `RST_COMP_TWO_CTRL_ONE);
        rd(4'h1, 8'h00);
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        wr(4'h0, 8'hFF);
        rd(4'h0, 8'h33);
        chk({6'h0, comp_one_ref_select, comp_two_ref_select}, 8'h03);
        wr(4'h0, 8'h00);
        rd(4'h0, 8'h00);
    end
    endtask
    task t_mirror;
    begin
        comp_one_result <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(4'h0, 8'h80);
        comp_one_result <= 1'b0;
        comp_two_result <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(4'h0, 8'h40);
        comp_two_result <= 1'b0;
        repeat (6) @(posedge core_clk);
    end
    endtask
    task t_gate;
    begin
        timer_on <= 1'b1;
        timer_gate_enable <= 1'b1;
        wr(4'h0, 8'h02);
        external_gate_pin <= 1'b1;
        @(negedge core_clk);
        chk1(timer_gate, 1'b1);
        @(posedge core_clk);
        external_gate_pin <= 1'b0;
        wr(4'h0, 8'h00);
        comp_two_result <= 1'b1;
        @(negedge core_clk);
        chk1(timer_gate, 1'b1);
        @(posedge core_clk);
        comp_two_result <= 1'b0;
        wr(4'h0, 8'h01);
        @(negedge timer_clk);
        @(posedge core_clk);
        comp_two_result <= 1'b1;
        @(negedge core_clk);
        chk1(synced_comp_two_result, 1'b0);
        @(negedge timer_clk);
        #1 chk1(synced_comp_two_result, 1'b1);
        @(posedge core_clk);
        timer_gate_enable <= 1'b0;
        @(negedge core_clk);
        chk1(timer_gate, 1'b0);
        @(posedge core_clk);
        comp_two_result <= 1'b0;
        timer_on <= 1'b0;
        wr(4'h0, 8'h00);
    end
    endtask
    task t_latch;
    begin
        wr(4'h1, 8'h08);
        chk1(latch_q, 1'b1);
        rd(4'h1, 8'h00);
        wr(4'h1, 8'h04);
        chk1(latch_q, 1'b0);
        wr(4'h1, 8'h08);
        wr(4'h1, 8'h0C);
        chk1(latch_q, 1'b0);
        comp_one_set_enable <= 1'b1;
        comp_one_result <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk1(latch_q, 1'b1);
        comp_two_reset_enable <= 1'b1;
        comp_two_result <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk1(latch_q, 1'b0);
        comp_one_set_enable <= 1'b0;
        comp_two_reset_enable <= 1'b0;
        comp_one_result <= 1'b0;
        wr(4'h1, 8'h08);
        repeat (6) @(posedge core_clk);
        chk({6'h0, pin_one, pin_two}, 8'h00);
        port_direction_bits <= 2'h0;
        comp_output_enable <= 2'h3;
        // table of {port one, port two} per select with q=1 c1=0 c2=1
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(4'h1, {i[1:0], 6'h00});
            chk({6'h0, port_out_one, port_out_two},
                (8'h4E >> (2 * (3 - i))) & 8'h03);
            chk({6'h0, pin_one, pin_two},
                (8'h4E >> (2 * (3 - i))) & 8'h03);
        end
        resetn <= 1'b0;
        @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk({6'h0, port_out_one, port_out_two}, 8'h01);
    end
    endtask
    initial
    begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_regs;
        t_mirror;
        t_gate;
        t_latch;
        final_report;
    end
    initial
    begin
        #100000;
        bad_count = bad_count + 1;
        final_report;
    end
endmodule
